// file: logic/alc_pkg.sv
package alc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int PADDR_W = 8;
  localparam int FADDR_W = 7;

  // ----------------------------------------------------------------
  // Instruction word fields
  // ----------------------------------------------------------------
  localparam int GRP_MSB = 13;
  localparam int GRP_LSB = 12;
  localparam int SUB_MSB = 11;
  localparam int SUB_LSB = 8;
  localparam int DEST_POS = 7;
  localparam int BIT_MSB = 9;
  localparam int BIT_LSB = 7;
  localparam int BITOP_MSB = 11;
  localparam int BITOP_LSB = 10;

  // Instruction groups in bits 13:12
  localparam logic [1:0] GRP_FILE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_JUMP = 2'h2;
  localparam logic [1:0] GRP_LIT = 2'h3;

  // File group sub-codes in bits 11:8
  localparam logic [3:0] F_MOVWF = 4'h0;
  localparam logic [3:0] F_CLR = 4'h1;
  localparam logic [3:0] F_SUB = 4'h2;
  localparam logic [3:0] F_DEC = 4'h3;
  localparam logic [3:0] F_IOR = 4'h4;
  localparam logic [3:0] F_AND = 4'h5;
  localparam logic [3:0] F_XOR = 4'h6;
  localparam logic [3:0] F_ADD = 4'h7;
  localparam logic [3:0] F_MOV = 4'h8;
  localparam logic [3:0] F_COM = 4'h9;
  localparam logic [3:0] F_INC = 4'hA;
  localparam logic [3:0] F_DECSZ = 4'hB;
  localparam logic [3:0] F_RR = 4'hC;
  localparam logic [3:0] F_RL = 4'hD;
  localparam logic [3:0] F_SWAP = 4'hE;
  localparam logic [3:0] F_INCSZ = 4'hF;

  // Bit group sub-codes in bits 11:10
  localparam logic [1:0] B_CLR = 2'h0;
  localparam logic [1:0] B_SET = 2'h1;
  localparam logic [1:0] B_SKIPCLR = 2'h2;
  localparam logic [1:0] B_SKIPSET = 2'h3;

  // Literal group sub-codes in bits 11:8
  localparam logic [3:0] L_MOV = 4'h0;
  localparam logic [3:0] L_ADD = 4'h1;
  localparam logic [3:0] L_SUB = 4'h2;
  localparam logic [3:0] L_AND = 4'h3;
  localparam logic [3:0] L_IOR = 4'h4;
  localparam logic [3:0] L_XOR = 4'h5;

  localparam logic [13:0] INSN_NOP = 14'h0000;

  // ----------------------------------------------------------------
  // Data space map
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_INDIRECT = 7'h00;
  localparam logic [6:0] ADDR_PCL = 7'h02;
  localparam logic [6:0] ADDR_STATUS = 7'h03;
  localparam logic [6:0] ADDR_FSR = 7'h04;
  localparam logic [6:0] GPR_BASE = 7'h20;
  localparam int GPR_DEPTH = 96;

  // Status bit positions and reset value
  localparam int FLAG_C = 0;
  localparam int FLAG_NC = 1;
  localparam int FLAG_Z = 2;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] STATUS_RO_MASK = 8'h18;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_COM, ALU_INC,
    ALU_DEC, ALU_RL, ALU_RR, ALU_SWAP, ALU_PASS, ALU_CLR
  } alc_alu_op_t;

  typedef struct packed {
    alc_alu_op_t op;
    logic [7:0] a;
    logic [7:0] b;
    logic carry_in;
  } alc_alu_req_t;

  typedef struct packed {
    logic [7:0] result;
    logic [2:0] flags;
    logic [2:0] affect;
  } alc_alu_rsp_t;

  typedef struct packed {
    logic [7:0] pc;
    logic [13:0] ir;
    logic [7:0] w;
    logic [7:0] status;
    logic [7:0] fsr;
  } alc_core_st_t;

endpackage

// file: logic/alc_alu.sv
`timescale 1ns/1ps
module alc_alu (
  input alc_pkg::alc_alu_req_t req, // Operation and operands
  output alc_pkg::alc_alu_rsp_t rsp // Result, flags and flag mask
);
  import alc_pkg::*;

  logic [8:0] sum9;
  logic [4:0] nib5;

  // ----------------------------------------------------------------
  // Eight-bit arithmetic and logic
  // ----------------------------------------------------------------
  // Subtraction is b minus a in two's complement, so carry high means no borrow
  always_comb begin
    sum9 = 9'h000;
    nib5 = 5'h00;
    rsp = '0;
    unique case (req.op)
      ALU_ADD: begin
        sum9 = {1'b0, req.b} + {1'b0, req.a};
        nib5 = {1'b0, req.b[3:0]} + {1'b0, req.a[3:0]};
        rsp.affect = 3'h7;
      end
      ALU_SUB: begin
        sum9 = {1'b0, req.b} + {1'b0, ~req.a} + 9'h001;
        nib5 = {1'b0, req.b[3:0]} + {1'b0, ~req.a[3:0]} + 5'h01;
        rsp.affect = 3'h7;
      end
      ALU_AND: begin
        sum9 = {1'b0, req.a & req.b};
        rsp.affect = 3'h4;
      end
      ALU_IOR: begin
        sum9 = {1'b0, req.a | req.b};
        rsp.affect = 3'h4;
      end
      ALU_XOR: begin
        sum9 = {1'b0, req.a ^ req.b};
        rsp.affect = 3'h4;
      end
      ALU_COM: begin
        sum9 = {1'b0, ~req.b};
        rsp.affect = 3'h4;
      end
      ALU_INC: begin
        sum9 = {1'b0, req.b + 8'h01};
        rsp.affect = 3'h4;
      end
      ALU_DEC: begin
        sum9 = {1'b0, req.b - 8'h01};
        rsp.affect = 3'h4;
      end
      ALU_RL: begin
        sum9 = {req.b, req.carry_in};
        rsp.affect = 3'h1;
      end
      ALU_RR: begin
        sum9 = {req.b[0], req.carry_in, req.b[7:1]};
        rsp.affect = 3'h1;
      end
      ALU_SWAP: sum9 = {1'b0, req.b[3:0], req.b[7:4]};
      ALU_PASS: begin
        sum9 = {1'b0, req.b};
        rsp.affect = 3'h4;
      end
      ALU_CLR: begin
        sum9 = 9'h000;
        rsp.affect = 3'h4;
      end
      default: sum9 = 9'h000;
    endcase
    rsp.result = sum9[7:0];
    // flags from bit 7, bit 3 and zero
    rsp.flags[FLAG_C] = sum9[8];
    rsp.flags[FLAG_NC] = nib5[4];
    rsp.flags[FLAG_Z] = (sum9[7:0] == 8'h00);
  end

endmodule

// file: logic/alc_dfile.sv
`timescale 1ns/1ps
module alc_dfile (
  input wire logic clk_sys, // Core clock
  input wire logic [6:0] rd_addr, // Read address
  output logic [7:0] rd_data, // Read data, same cycle
  input wire logic wr_en, // Write strobe
  input wire logic [6:0] wr_addr, // Write address
  input wire logic [7:0] wr_data // Write data
);
  import alc_pkg::*;

  logic [7:0] gpr [GPR_DEPTH];
  logic rd_hit;
  logic wr_hit;
  logic [6:0] rd_idx;
  logic [6:0] wr_idx;

  // ----------------------------------------------------------------
  // General purpose bytes
  // ----------------------------------------------------------------
  // Addresses outside the array read as zero and ignore writes
  always_comb begin
    rd_hit = (rd_addr >= GPR_BASE);
    wr_hit = (wr_addr >= GPR_BASE);
    rd_idx = rd_addr - GPR_BASE;
    wr_idx = wr_addr - GPR_BASE;
    rd_data = rd_hit ? gpr[rd_idx] : 8'h00;
  end

  // Contents are not reset, as with plain RAM
  always_ff @(posedge clk_sys) begin
    if (wr_en && wr_hit) begin
      gpr[wr_idx] <= wr_data;
    end
  end

endmodule

// file: logic/alc_core.sv
// Functional notes
// - Program and data sit on separate buses, used in the same cycle.
// - Each instruction is one 14-bit word; no multi-word forms.
// - The 14-bit program bus delivers one whole word per cycle.
// - Two-stage pipeline: next fetch overlaps current execute.
// - Every instruction takes one cycle; taken branches and skips cost one more.
// - Data path is 8 bits, separate from the instruction width.
// - Data file reached directly from the word or through the pointer.
// - Program counter, status and pointer live in the data space.
// - Any operation works on any file address with any addressing.
// - The ALU is 8 bits: add, subtract, shifts, logic.
// - Arithmetic is two's complement.
// - Two-operand forms use the working register and a file or literal.
// - Single-operand forms act on the working register or a file.
// - Working register is 8 bits and has no data address.
// - Operations update carry, nibble carry and zero as they require.
// - In subtraction carry and nibble carry mean no borrow.
// - Flag logic owns the three flag bits when a flag-affecting operation writes status; a store or swap writes them as data.
`timescale 1ns/1ps
module alc_core (
  input wire logic clk_sys, // Core clock, 25 MHz
  input wire logic srst, // Synchronous reset, active high
  output logic [alc_pkg::PADDR_W-1:0] prog_addr, // Program memory address
  input wire logic [alc_pkg::INSN_W-1:0] prog_data, // Program word at prog_addr
  output logic [7:0] w_value, // Working register contents
  output logic [7:0] status_value // Status register contents
);
  import alc_pkg::*;

  // ----------------------------------------------------------------
  // State and decode signals
  // ----------------------------------------------------------------
  alc_core_st_t st;
  alc_core_st_t next_st;
  alc_alu_req_t alu_req;
  alc_alu_rsp_t alu_rsp;

  logic [1:0] grp;
  logic [3:0] sub;
  logic [1:0] bitop;
  logic [2:0] bitnum;
  logic dest_file;
  logic [6:0] faddr;
  logic [6:0] eaddr;
  logic [7:0] lit;
  logic [7:0] gpr_rd;
  logic [7:0] fval;
  logic [7:0] bitmask;
  logic [7:0] wr_val;
  logic wr_file;
  logic wr_w;
  logic take_flags;
  logic skip;
  logic branch;
  logic [7:0] status_wr;
  logic gpr_wr;
  // Write targets, decoded once
  logic to_pcl;
  logic to_status;
  logic to_fsr;
  logic flag_owner;

  // Map a file-group sub-code onto an ALU operation
  function automatic alc_alu_op_t file_op(input logic [3:0] code);
    unique case (code)
      F_MOVWF: file_op = ALU_PASS;
      F_CLR: file_op = ALU_CLR;
      F_SUB: file_op = ALU_SUB;
      F_DEC, F_DECSZ: file_op = ALU_DEC;
      F_IOR: file_op = ALU_IOR;
      F_AND: file_op = ALU_AND;
      F_XOR: file_op = ALU_XOR;
      F_ADD: file_op = ALU_ADD;
      F_MOV: file_op = ALU_PASS;
      F_COM: file_op = ALU_COM;
      F_INC, F_INCSZ: file_op = ALU_INC;
      F_RR: file_op = ALU_RR;
      F_RL: file_op = ALU_RL;
      F_SWAP: file_op = ALU_SWAP;
      default: file_op = ALU_PASS;
    endcase
  endfunction

  // Map a literal-group sub-code onto an ALU operation
  function automatic alc_alu_op_t lit_op(input logic [3:0] code);
    unique case (code)
      L_ADD: lit_op = ALU_ADD;
      L_SUB: lit_op = ALU_SUB;
      L_AND: lit_op = ALU_AND;
      L_IOR: lit_op = ALU_IOR;
      L_XOR: lit_op = ALU_XOR;
      default: lit_op = ALU_PASS;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Field extraction and operand fetch
  // ----------------------------------------------------------------
  // Word layout: bits 13:12 pick the group, the rest depends on it
  //   file    : op 11:8, destination 7 (1 = file, 0 = working), address 6:0
  //   bit     : op 11:10, bit number 9:7, address 6:0
  //   jump    : target 7:0, costs one flushed fetch
  //   literal : op 11:8, constant 7:0; unused codes fall back to a move
  // whole instruction in one word
  always_comb begin
    grp = st.ir[GRP_MSB:GRP_LSB];
    sub = st.ir[SUB_MSB:SUB_LSB];
    bitop = st.ir[BITOP_MSB:BITOP_LSB];
    bitnum = st.ir[BIT_MSB:BIT_LSB];
    dest_file = st.ir[DEST_POS];
    faddr = st.ir[FADDR_W-1:0];
    lit = st.ir[DATA_W-1:0];
    bitmask = 8'h01 << bitnum;
  end

  // Only the low seven pointer bits reach the data space
  // direct or through the pointer
  assign eaddr = (faddr == ADDR_INDIRECT) ? st.fsr[FADDR_W-1:0] : faddr;

  // Data space: 0x00 through the pointer, 0x02 counter, 0x03 status,
  // 0x04 pointer, 0x20 up to 0x7F plain bytes; others read as zero
  // A pointer of zero reads zero, so an indirect loop cannot feed on itself
  // special registers read like any file byte
  always_comb begin
    unique case (eaddr)
      ADDR_INDIRECT: fval = 8'h00;
      ADDR_PCL: fval = st.pc;
      ADDR_STATUS: fval = st.status;
      ADDR_FSR: fval = st.fsr;
      default: fval = gpr_rd;
    endcase
  end

  // ----------------------------------------------------------------
  // Data file and ALU
  // ----------------------------------------------------------------
  // The array filters out addresses below its base by itself
  // data bus runs alongside the program fetch
  alc_dfile u_dfile (
    .clk_sys(clk_sys),
    .rd_addr(eaddr),
    .rd_data(gpr_rd),
    .wr_en(gpr_wr),
    .wr_addr(eaddr),
    .wr_data(wr_val)
  );

  // working register with a file byte or literal
  always_comb begin
    alu_req.a = st.w;
    alu_req.carry_in = st.status[FLAG_C];
    if (grp == GRP_LIT) begin
      alu_req.op = lit_op(sub);
      alu_req.b = lit;
    end else if (grp == GRP_FILE && sub == F_MOVWF) begin
      // store working register as the sole operand
      alu_req.op = ALU_PASS;
      alu_req.b = st.w;
    end else begin
      alu_req.op = file_op(sub);
      alu_req.b = fval;
    end
  end

  // Purely combinational; the result settles within the execute cycle
  alc_alu u_alu (
    .req(alu_req),
    .rsp(alu_rsp)
  );

  // ----------------------------------------------------------------
  // Execute: destinations, skips and jumps
  // ----------------------------------------------------------------
  // every file address takes every operation
  always_comb begin
    wr_val = alu_rsp.result;
    wr_file = 1'b0;
    wr_w = 1'b0;
    take_flags = 1'b0;
    skip = 1'b0;
    branch = 1'b0;
    unique case (grp)
      GRP_FILE: begin
        // Sub-code zero with the working register as target is the no-op
        wr_file = dest_file;
        wr_w = !dest_file && (sub != F_MOVWF);
        // only when the operation affects them
        take_flags = (sub != F_MOVWF);
        // A skip flushes the fetched word instead of stalling the fetch
        if (sub == F_DECSZ || sub == F_INCSZ) begin
          take_flags = 1'b0;
          skip = alu_rsp.flags[FLAG_Z];
        end
      end
      GRP_BIT: begin
        unique case (bitop)
          B_CLR: begin
            wr_val = fval & ~bitmask;
            wr_file = 1'b1;
          end
          B_SET: begin
            wr_val = fval | bitmask;
            wr_file = 1'b1;
          end
          B_SKIPCLR: skip = ((fval & bitmask) == 8'h00);
          B_SKIPSET: skip = ((fval & bitmask) != 8'h00);
        endcase
      end
      // Target comes from the low byte; the flush sits in next state
      GRP_JUMP: branch = 1'b1;
      // Literal results always land in the working register
      GRP_LIT: begin
        wr_w = 1'b1;
        take_flags = 1'b1;
      end
    endcase
  end

  // Only plain bytes go to the array; special registers live in the state
  assign gpr_wr = wr_file && (eaddr >= GPR_BASE);

  // ----------------------------------------------------------------
  // Write targets in the data space
  // ----------------------------------------------------------------
  // One decode shared by status, pointer and counter updates, so the
  // three can never disagree on which byte an instruction writes
  always_comb begin
    to_pcl = wr_file && (eaddr == ADDR_PCL);
    to_status = wr_file && (eaddr == ADDR_STATUS);
    to_fsr = wr_file && (eaddr == ADDR_FSR);
    // any flag-affecting op owns all three
    flag_owner = take_flags && (alu_rsp.affect != 3'h0);
  end

  // Status after any direct write, then the flag logic on top
  always_comb begin
    status_wr = st.status;
    if (to_status) begin
      status_wr = (wr_val & ~STATUS_RO_MASK) | (st.status & STATUS_RO_MASK);
      // Flag bits keep their old value; unaffected ones stay as they were
      if (flag_owner) begin
        status_wr[FLAG_Z:FLAG_C] = st.status[FLAG_Z:FLAG_C];
      end
    end
    // flag logic beats the data write
    if (take_flags) begin
      status_wr = (status_wr & ~{5'h00, alu_rsp.affect}) |
                  ({5'h00, alu_rsp.flags} & {5'h00, alu_rsp.affect});
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Limitation: an eight-bit counter and no call stack, so a program spans
  // 256 words and every branch is an absolute jump or a counter write
  // fetch of the next word overlaps this execute
  always_comb begin
    next_st = st;
    next_st.status = status_wr;
    next_st.pc = st.pc + 8'h01;
    next_st.ir = prog_data;
    // working register has no file address
    if (wr_w) begin
      next_st.w = alu_rsp.result;
    end
    if (to_fsr) begin
      next_st.fsr = wr_val;
    end
    // taken branches drop the word already fetched
    if (branch) begin
      next_st.pc = lit;
      next_st.ir = INSN_NOP;
    end else if (to_pcl) begin
      next_st.pc = wr_val;
      next_st.ir = INSN_NOP;
    end else if (skip) begin
      next_st.ir = INSN_NOP;
    end
  end

  // Reset clears the pipeline to a no-op so the first word is fetched cleanly
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st.pc <= 8'h00;
      st.ir <= INSN_NOP;
      st.w <= 8'h00;
      st.status <= STATUS_RST;
      st.fsr <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // one full word fetched per cycle at the counter
  assign prog_addr = st.pc;
  // byte-wide data views, straight from flops
  assign w_value = st.w;
  assign status_value = st.status;

endmodule

// file: sim/alc_prog_rom.sv
`timescale 1ns/1ps
module alc_prog_rom (
  input wire logic [alc_pkg::PADDR_W-1:0] prog_addr, // Fetch address
  output logic [alc_pkg::INSN_W-1:0] prog_data // Word at that address
);
  import alc_pkg::*;
  // Program image, loaded by the bench just before it asserts reset
  logic [INSN_W-1:0] mem [256];

  // one whole word
  // Asynchronous read keeps the fetch apart from any data access
  assign prog_data = mem[prog_addr];
endmodule

// file: sim/alc_core_properties.sv
`timescale 1ns/1ps
module alc_core_properties
  import alc_pkg::*;
(
  input wire logic clk_sys, // Core clock
  input wire logic srst, // Synchronous reset
  input wire logic [alc_pkg::PADDR_W-1:0] prog_addr, // Fetch address
  input wire logic [alc_pkg::INSN_W-1:0] prog_data, // Fetched word
  input wire logic [7:0] w_value, // Working register
  input wire logic [7:0] status_value // Status register
);
  typedef struct packed {
    logic [13:0] w1;
    logic [13:0] w2;
    logic [7:0] pw;
  } alc_hist_t;
  alc_hist_t hist;
  alc_hist_t next_hist;
  logic calm;
  logic lit;
  logic [3:0] lop;

  // Word history; reset loads a no-op just as the pipeline does
  always_comb begin
    next_hist.w1 = srst ? INSN_NOP : prog_data;
    next_hist.w2 = srst ? INSN_NOP : hist.w1;
    next_hist.pw = w_value;
  end
  always_ff @(posedge clk_sys) begin
    hist <= next_hist;
  end
  // Executing word cannot flush, so the word fetched now will run
  assign calm = (hist.w1[13:12] == GRP_LIT) || (hist.w1 == INSN_NOP);
  assign lit = calm && (prog_data[13:12] == GRP_LIT);
  assign lop = prog_data[11:8];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  pc_step_a: assert property (calm |=> prog_addr == 8'($past(prog_addr) + 8'h01))
    else $error("fetch address did not advance");
  jump_target_a: assert property (calm && prog_data[13:12] == GRP_JUMP
    |=> ##1 prog_addr == hist.w2[7:0]) else $error("jump target wrong");
  lit_move_a: assert property (lit && lop == L_MOV |=> ##1 w_value == hist.w2[7:0]
    && $stable(status_value[1:0]) && status_value[FLAG_Z] == (w_value == 8'h00))
    else $error("literal move wrong");
  lit_add_a: assert property (lit && lop == L_ADD |=> ##1
    {status_value[FLAG_C], w_value} == {1'b0, hist.pw} + {1'b0, hist.w2[7:0]})
    else $error("add result or carry wrong");
  nibble_add_a: assert property (lit && lop == L_ADD |=> ##1
    status_value[FLAG_NC] == ((5'(hist.pw[3:0]) + 5'(hist.w2[3:0])) > 5'd15))
    else $error("add nibble carry wrong");
  lit_sub_a: assert property (lit && lop == L_SUB |=> ##1
    w_value == 8'(hist.w2[7:0] - hist.pw) && status_value[FLAG_C] == (hist.w2[7:0] >= hist.pw)
    && status_value[FLAG_NC] == (hist.w2[3:0] >= hist.pw[3:0])) else $error("subtract wrong");
  lit_and_a: assert property (lit && lop == L_AND |=> ##1
    w_value == (hist.pw & hist.w2[7:0])) else $error("logic and wrong");
  zero_flag_a: assert property (lit && (lop == L_IOR || lop == L_XOR)
    |=> ##1 status_value[FLAG_Z] == (w_value == 8'h00)) else $error("zero flag wrong");
  status_fixed_a: assert property (status_value[4:3] == 2'b11)
    else $error("read-only status bits changed");

  cover property (calm && prog_data[13:12] == GRP_JUMP);
  cover property (lit && lop == L_SUB ##2 !status_value[FLAG_C]);
  cover property (lit && lop == L_ADD ##2 status_value[FLAG_C]);
endmodule

// file: sim/test_eight_bit_alu_core_datapath.sv
`timescale 1ns/1ps
module test_eight_bit_alu_core_datapath;
  import alc_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] prog_addr;
  logic [13:0] prog_data;
  logic [7:0] w_value;
  logic [7:0] status_value;
  int fail_count = 0;
  int cmp_count = 0;
  logic [13:0] img [64];
  logic [7:0] ew [10];
  logic [7:0] es [10];

  // ----------------------------------------------------------------
  // Clock, design and program memory
  // ----------------------------------------------------------------
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  alc_core DUT (.clk_sys(clk_sys), .srst(srst), .prog_addr(prog_addr),
    .prog_data(prog_data), .w_value(w_value), .status_value(status_value));
  alc_prog_rom rom (.prog_addr(prog_addr), .prog_data(prog_data));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [13:0] lit(input logic [3:0] op, input logic [7:0] k);
    return {GRP_LIT, op, k};
  endfunction
  function automatic logic [13:0] fil(input logic [3:0] op, input logic d, input logic [6:0] f);
    return {GRP_FILE, op, d, f};
  endfunction
  function automatic logic [13:0] bop(input logic [1:0] op, input logic [2:0] b,
    input logic [6:0] f);
    return {GRP_BIT, op, b, f};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Loads the image, resets, then checks the state after every cycle but the first
  task automatic run_seq(input int n, input string name);
    for (int i = 0; i < 256; i++) rom.mem[i] = (i < 64) ? img[i] : INSN_NOP;
    srst = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(prog_addr, 8'h00);
    check(status_value, STATUS_RST);
    srst = 1'b0;
    @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      check(w_value, ew[i]);
      check(status_value, es[i]);
    end
    $display("test %s done", name);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Literal arithmetic with carries, borrows and zero results
  task automatic t_literal();
    img = '{default: INSN_NOP};
    img[0:8] = '{lit(L_MOV, 8'h0F), lit(L_ADD, 8'h01), lit(L_ADD, 8'hF0), lit(L_MOV, 8'h05),
      lit(L_SUB, 8'h03), lit(L_AND, 8'h0F), lit(L_XOR, 8'h0E), lit(L_IOR, 8'h81),
      lit(L_SUB, 8'h81)};
    ew = '{8'h0F, 8'h10, 8'h00, 8'h05, 8'hFE, 8'h0E, 8'h00, 8'h81, 8'h00, 8'h00};
    es = '{8'h18, 8'h1A, 8'h1D, 8'h19, 8'h18, 8'h18, 8'h1C, 8'h18, 8'h1F, 8'h00};
    run_seq(9, "literal");
  endtask
  // File operands, direct and through the pointer, shifts on carry
  task automatic t_file();
    img = '{default: INSN_NOP};
    img[0:9] = '{lit(L_MOV, 8'h5A), fil(F_MOVWF, 1'b1, 7'h20), lit(L_MOV, 8'h20),
      fil(F_MOVWF, 1'b1, ADDR_FSR), fil(F_CLR, 1'b0, 7'h00), fil(F_ADD, 1'b0, ADDR_INDIRECT),
      fil(F_COM, 1'b1, ADDR_INDIRECT), fil(F_RL, 1'b0, 7'h20), fil(F_MOV, 1'b0, 7'h20),
      fil(F_RR, 1'b0, ADDR_INDIRECT)};
    ew = '{8'h5A, 8'h5A, 8'h20, 8'h20, 8'h00, 8'h5A, 8'h5A, 8'h4A, 8'hA5, 8'hD2};
    es = '{8'h18, 8'h18, 8'h18, 8'h18, 8'h1C, 8'h18, 8'h18, 8'h19, 8'h19, 8'h19};
    run_seq(10, "file");
  endtask
  // Jump and program counter write each drop the word behind them
  task automatic t_branch();
    img = '{default: INSN_NOP};
    img[0:2] = '{lit(L_MOV, 8'h11), {GRP_JUMP, 4'h0, 8'h10}, lit(L_MOV, 8'hEE)};
    img[16:19] = '{lit(L_MOV, 8'h33), lit(L_MOV, 8'h30), fil(F_MOVWF, 1'b1, ADDR_PCL),
      lit(L_MOV, 8'hEE)};
    img[48] = lit(L_ADD, 8'h01);
    ew = '{8'h11, 8'h11, 8'h11, 8'h33, 8'h30, 8'h30, 8'h30, 8'h31, 8'h00, 8'h00};
    es = '{default: 8'h18};
    run_seq(8, "branch");
  endtask
  // Status as destination: flag logic wins, bits 4:3 hold
  task automatic t_status();
    img = '{default: INSN_NOP};
    img[0:9] = '{lit(L_MOV, 8'hFF), lit(L_ADD, 8'h01), lit(L_MOV, 8'hE0),
      fil(F_MOVWF, 1'b1, ADDR_STATUS), fil(F_CLR, 1'b1, ADDR_STATUS), lit(L_MOV, 8'h07),
      fil(F_MOVWF, 1'b1, ADDR_STATUS), fil(F_INC, 1'b1, ADDR_STATUS),
      fil(F_SWAP, 1'b1, ADDR_STATUS), fil(F_RR, 1'b1, ADDR_STATUS)};
    ew = '{8'hFF, 8'h00, 8'hE0, 8'hE0, 8'hE0, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07};
    es = '{8'h18, 8'h1F, 8'h1B, 8'hF8, 8'h1C, 8'h18, 8'h1F, 8'h3B, 8'hBB, 8'hDB};
    run_seq(10, "status");
  endtask
  // Bit set, clear and test, a file skip and a bit-clear skip, file subtract and file move
  task automatic t_bits();
    img = '{default: INSN_NOP};
    img[0:9] = '{lit(L_MOV, 8'h01), fil(F_MOVWF, 1'b1, 7'h21), fil(F_DECSZ, 1'b1, 7'h21),
      lit(L_MOV, 8'hFF), bop(B_SET, 3'h7, 7'h21), bop(B_SKIPCLR, 3'h6, 7'h21),
      lit(L_MOV, 8'hFF), fil(F_SUB, 1'b0, 7'h21), bop(B_CLR, 3'h7, 7'h21),
      fil(F_MOV, 1'b0, 7'h21)};
    ew = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h7F, 8'h7F, 8'h00};
    es = '{8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h19, 8'h19, 8'h1D};
    run_seq(10, "bits");
  endtask

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    t_literal();
    t_file();
    t_branch();
    t_status();
    t_bits();
    results();
  end
  // Whole run is about 62 cycles; far more means a hang
  initial begin
    #(40 * 1000);
    fail_count++;
    results();
  end
endmodule

bind alc_core alc_core_properties u_props (.clk_sys(clk_sys), .srst(srst),
  .prog_addr(prog_addr), .prog_data(prog_data), .w_value(w_value),
  .status_value(status_value));
